// ===== rtl/swbuck_config_regs.sv
// What this block does
// - cut-off bit forces switch off on power-fail
// - discharge bit discharges switch output while off
// - switch register resets zero, bits 7:6 read 0
// - writes accepted only while password unlocked
// - buck voltage write blanks monitoring 5 ms
// - bit 7 selects light-load pulse skipping
// - bit 6 reserved zero; reset value 0x99
// - buck one code six bits, reset 19h
// - buck two code same encoding, 19h
//
// register slice for load switches and two bucks
// assumes a decoded byte register port and an unlock level from elsewhere
// assumes the apply level comes from the apply logic at 0x1A
// assumes the power-fail pin is asynchronous to CLK_SYS
`timescale 1ns/1ps
module swbuck_config_regs
  import swbuck_pkg::*;
(
  // clock, reset, enable
  input  wire logic             CLK_SYS,
  input  wire logic             SYS_RST,
  input  wire logic             CLK_EN,
  // register port
  input  wire logic [7:0]       REG_ADDR,
  input  wire logic [7:0]       REG_WDATA,
  input  wire logic             REG_WR,
  input  wire logic             REG_RD,
  output logic      [7:0]       REG_RDATA,
  // password state and apply request
  input  wire logic             WRITE_UNLOCKED,
  input  wire logic             VOLTAGE_APPLY,
  // switches
  input  wire logic [2:0]       SWITCH_ENABLE,
  input  wire logic             POWERFAIL_FLAG_LOW_N_PIN,
  output logic      [2:0]       SWITCH_ON,
  output logic      [2:0]       SWITCH_DISCHARGE,
  // buck controls
  output logic      [CODE_W-1:0] BUCK_ONE_TARGET,
  output logic      [CODE_W-1:0] BUCK_TWO_TARGET,
  output logic                  BUCK_ONE_SKIP,
  output logic                  BUCK_TWO_SKIP,
  output logic                  MONITOR_BLANK
);
  // stored register contents
  logic [7:0]         lsw_reg, lsw_next;
  logic [7:0]         b1_reg, b1_next;
  logic [7:0]         b2_reg, b2_next;
  // applied regulator targets
  logic [CODE_W-1:0]  t1_reg, t1_next, t2_reg, t2_next;
  // read data
  logic [7:0]         rd_reg, rd_next;
  // blanking counter and flag
  logic [BLANK_W-1:0] blk_reg, blk_next;
  logic               blank_reg, blank_next;
  // power-fail synchroniser
  logic [2:0]         pf_sync_reg, pf_sync_next;
  logic               pf_stable_reg, pf_stable_next;
  // accepted write strobes
  logic               wr_ok, wr_b1, wr_b2;

  // decode of accepted writes
  // locked writes vanish silently; nothing flags them to the host
  always_comb begin
    wr_ok = REG_WR & WRITE_UNLOCKED;
    wr_b1 = wr_ok & (REG_ADDR == ADDR_BUCK_ONE_VOLTAGE);
    wr_b2 = wr_ok & (REG_ADDR == ADDR_BUCK_TWO_VOLTAGE);
  end

  // register contents; reserved bits masked off
  // reserved positions are cleared on the way in, so reads return zero
  always_comb begin
    lsw_next = lsw_reg;
    b1_next  = b1_reg;
    b2_next  = b2_reg;
    if (wr_ok && REG_ADDR == ADDR_LOAD_SWITCH_CONFIG)
      lsw_next = REG_WDATA & MASK_LOAD_SWITCH_CONFIG;
    if (wr_b1)
      b1_next = REG_WDATA & MASK_BUCK_VOLTAGE;
    if (wr_b2)
      b2_next = REG_WDATA & MASK_BUCK_VOLTAGE;
  end

  // regulator targets follow stored codes only on apply
  // a code written in the apply cycle itself waits for the next apply
  // both targets move together on one apply level
  always_comb begin
    t1_next = t1_reg;
    t2_next = t2_reg;
    if (VOLTAGE_APPLY) begin
      t1_next = b1_reg[CODE_LSB +: CODE_W];
      t2_next = b2_reg[CODE_LSB +: CODE_W];
    end
  end

  // blanking counter restarts on every unlocked buck voltage write
  // the count runs on enabled cycles only, so a held clock enable
  // stretches the blanking interval in real time
  always_comb begin
    blk_next   = blk_reg;
    blank_next = blank_reg;
    if (wr_b1 || wr_b2) begin
      blk_next   = BLANK_W'(BLANK_CYCLES - 1);
      blank_next = 1'b1;
    end else if (blk_reg != '0) begin
      blk_next = blk_reg - 1'b1;
    end else begin
      blank_next = 1'b0;
    end
  end

  // read mux
  // a read and a write in one cycle return the old contents
  // unmapped subaddresses read as zero
  always_comb begin
    rd_next = rd_reg;
    if (REG_RD) begin
      case (REG_ADDR)
        ADDR_LOAD_SWITCH_CONFIG: rd_next = lsw_reg;
        ADDR_BUCK_ONE_VOLTAGE:   rd_next = b1_reg;
        ADDR_BUCK_TWO_VOLTAGE:   rd_next = b2_reg;
        default:                 rd_next = RDATA_IDLE;
      endcase
    end
  end

  // power-fail pin: three stages, change taken once two and three agree
  // the first stage may go metastable, so only the shift reads it
  always_comb begin
    pf_sync_next   = {pf_sync_reg[1:0], POWERFAIL_FLAG_LOW_N_PIN};
    pf_stable_next = pf_stable_reg;
    if (pf_sync_reg[1] == pf_sync_reg[2])
      pf_stable_next = pf_sync_reg[2];
  end

  // register contents; reset wins over the clock enable
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      lsw_reg <= RST_LOAD_SWITCH_CONFIG;
      b1_reg  <= RST_BUCK_VOLTAGE;
      b2_reg  <= RST_BUCK_VOLTAGE;
    end else if (CLK_EN) begin
      lsw_reg <= lsw_next;
      b1_reg  <= b1_next;
      b2_reg  <= b2_next;
    end
  end

  // applied targets start from the reset code of the stored registers
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      t1_reg <= RST_BUCK_VOLTAGE[CODE_LSB +: CODE_W];
      t2_reg <= RST_BUCK_VOLTAGE[CODE_LSB +: CODE_W];
    end else if (CLK_EN) begin
      t1_reg <= t1_next;
      t2_reg <= t2_next;
    end
  end

  // blanking counter and flag; reset ends any blanking in progress
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      blk_reg   <= '0;
      blank_reg <= 1'b0;
    end else if (CLK_EN) begin
      blk_reg   <= blk_next;
      blank_reg <= blank_next;
    end
  end

  // read data register; holds until the next read strobe
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      rd_reg <= RDATA_IDLE;
    end else if (CLK_EN) begin
      rd_reg <= rd_next;
    end
  end

  // synchroniser starts at the no-fail level, so reset shows no false trip
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      pf_sync_reg   <= {3{PF_IDLE_LEVEL}};
      pf_stable_reg <= PF_IDLE_LEVEL;
    end else if (CLK_EN) begin
      pf_sync_reg   <= pf_sync_next;
      pf_stable_reg <= pf_stable_next;
    end
  end

  // one controller per load switch
  // each controller registers its outputs, so a cut-off lands one
  // cycle after the synchronised flag drops, four to five cycles
  // after the pin itself
  genvar g;
  generate
    for (g = 0; g < NUM_SWITCHES; g++) begin : g_sw
      swbuck_switch_ctrl u_sw (
        .clk                (CLK_SYS),
        .rst                (SYS_RST),
        .ce                 (CLK_EN),
        .switch_enable      (SWITCH_ENABLE[g]),
        .powerfail_cutoff   (lsw_reg[CUTOFF_LSB + g]),
        .discharge_enable   (lsw_reg[DISCHARGE_LSB + g]),
        .powerfail_flag_low (pf_stable_reg),
        .switch_on          (SWITCH_ON[g]),
        .discharge_on       (SWITCH_DISCHARGE[g])
      );
    end
  endgenerate

  // outputs straight from flip-flops
  // skip bits reach the converters without waiting for apply
  assign REG_RDATA       = rd_reg;
  assign BUCK_ONE_TARGET = t1_reg;
  assign BUCK_TWO_TARGET = t2_reg;
  assign BUCK_ONE_SKIP   = b1_reg[SKIP_BIT];
  assign BUCK_TWO_SKIP   = b2_reg[SKIP_BIT];
  assign MONITOR_BLANK   = blank_reg;
endmodule

// ===== rtl/swbuck_pkg.sv
// constants for the load-switch and buck configuration register slice
// assumes an 8-bit register port driven by the serial-interface decoder
package swbuck_pkg;
  localparam logic [7:0] ADDR_LOAD_SWITCH_CONFIG = 8'h15;
  localparam logic [7:0] ADDR_BUCK_ONE_VOLTAGE   = 8'h16;
  localparam logic [7:0] ADDR_BUCK_TWO_VOLTAGE   = 8'h17;
  localparam logic [7:0] RST_LOAD_SWITCH_CONFIG  = 8'h00;
  localparam logic [7:0] RST_BUCK_VOLTAGE        = 8'h99;
  // writable bit masks; reserved bits read zero
  localparam logic [7:0] MASK_LOAD_SWITCH_CONFIG = 8'h3F;
  localparam logic [7:0] MASK_BUCK_VOLTAGE       = 8'hBF;
  localparam int         CUTOFF_LSB              = 3;
  localparam int         DISCHARGE_LSB           = 0;
  localparam int         SKIP_BIT                = 7;
  localparam int         CODE_LSB                = 0;
  localparam int         CODE_W                  = 6;
  localparam int         NUM_SWITCHES            = 3;
  // blanking time after a buck voltage write
  localparam int         CLK_HZ                  = 25000000;
  localparam int         BLANK_TIME_MS           = 5;
  localparam int         BLANK_CYCLES            = CLK_HZ / 1000 * BLANK_TIME_MS;
  localparam int         BLANK_W                 = 18;
  // read data at reset and for unmapped subaddresses
  localparam logic [7:0] RDATA_IDLE              = 8'h00;
  // power-fail pin level while no failure is present
  localparam logic       PF_IDLE_LEVEL           = 1'b1;
endpackage

// ===== rtl/swbuck_switch_ctrl.sv
// one load switch: gates its enable by power-fail and drives discharge
// assumes the power-fail flag is already synchronised to CLK_SYS
`timescale 1ns/1ps
module swbuck_switch_ctrl (
  // clocking
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // controls
  input  wire logic switch_enable,
  input  wire logic powerfail_cutoff,
  input  wire logic discharge_enable,
  input  wire logic powerfail_flag_low,
  // outputs
  output logic      switch_on,
  output logic      discharge_on
);
  logic on_reg, on_next, dis_reg, dis_next;

  // switch forced off while power-fail is low and cut-off is set
  always_comb begin
    on_next  = switch_enable & ~(powerfail_cutoff & ~powerfail_flag_low);
    dis_next = discharge_enable & ~on_next;
  end

  // register both outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      on_reg  <= 1'b0;
      dis_reg <= 1'b0;
    end else if (ce) begin
      on_reg  <= on_next;
      dis_reg <= dis_next;
    end
  end

  assign switch_on    = on_reg;
  assign discharge_on = dis_reg;
endmodule

// ===== testbench/swbuck_host_model.sv
// host model: issues byte cycles on the decoded register port
// assumes the bench calls its tasks; changes land at falling edges
`timescale 1ns/1ps
module swbuck_host_model (
  // clock
  input  wire logic clk,
  // register port
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic       wr,
  output logic       rd,
  output logic       unlocked,
  output logic       apply
);
  // idle bus at time zero
  initial {addr, wdata, wr, rd, unlocked, apply} = '0;
  // one write, unlocked only around it; data scrambled once released
  task automatic write(input logic [7:0] a, d, input logic u);
    @(negedge clk);
    {addr, wdata, unlocked, wr} = {a, d, u, 1'b1};
    @(negedge clk);
    {wdata, unlocked, wr} = {~d, 2'b00};
  endtask
  // one read strobe
  task automatic read(input logic [7:0] a);
    @(negedge clk);
    {addr, rd} = {a, 1'b1};
    @(negedge clk);
    {addr, rd} = {~a, 1'b0};
  endtask
  // apply pulse as the apply register logic sends it
  task automatic go();
    @(negedge clk);
    apply = 1'b1;
    @(negedge clk);
    apply = 1'b0;
  endtask
endmodule

// ===== testbench/swbuck_monitor.sv
// checker: port-level properties of the register slice
// assumes it is bound onto swbuck_config_regs
`timescale 1ns/1ps
module swbuck_monitor
  import swbuck_pkg::*;
(
  // clocking
  input wire logic              CLK_SYS,
  input wire logic              SYS_RST,
  input wire logic              CLK_EN,
  // register port
  input wire logic [7:0]        REG_ADDR,
  input wire logic              REG_WR,
  input wire logic              REG_RD,
  input wire logic [7:0]        REG_RDATA,
  input wire logic              WRITE_UNLOCKED,
  input wire logic              VOLTAGE_APPLY,
  // switch and buck side
  input wire logic [2:0]        SWITCH_ENABLE,
  input wire logic [2:0]        SWITCH_ON,
  input wire logic [2:0]        SWITCH_DISCHARGE,
  input wire logic [CODE_W-1:0] BUCK_ONE_TARGET,
  input wire logic [CODE_W-1:0] BUCK_TWO_TARGET,
  input wire logic              MONITOR_BLANK
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  // accepted buck write and enabled read of a buck register
  wire bw = CLK_EN & REG_WR & WRITE_UNLOCKED & (REG_ADDR[7:1] == 7'h0B);
  wire br = CLK_EN & REG_RD & (REG_ADDR[7:1] == 7'h0B);
  blank_start_a: assert property (bw |=> MONITOR_BLANK)
    else $error("blank did not start");
  blank_hold_a: assert property ($rose(MONITOR_BLANK) |-> MONITOR_BLANK[*8])
    else $error("blank dropped early");
  locked_quiet_a: assert property (REG_WR & ~WRITE_UNLOCKED & ~MONITOR_BLANK |=> ~MONITOR_BLANK)
    else $error("locked write blanked");
  target_hold_a: assert property (~VOLTAGE_APPLY |=> $stable(BUCK_ONE_TARGET) && $stable(BUCK_TWO_TARGET))
    else $error("target moved without apply");
  rsvd_top_a: assert property (CLK_EN & REG_RD & REG_ADDR == 8'h15 |=> REG_RDATA[7:6] == 2'b00)
    else $error("switch reserved bits set");
  rsvd_six_a: assert property (br |=> ~REG_RDATA[6])
    else $error("buck reserved bit set");
  dischg_off_a: assert property ((SWITCH_DISCHARGE & SWITCH_ON) == 3'h0)
    else $error("discharge while on");
  switch_gate_a: assert property (CLK_EN |=> (SWITCH_ON & ~$past(SWITCH_ENABLE)) == 3'h0)
    else $error("switch on without enable");
  cover property (bw);
  cover property (VOLTAGE_APPLY);
  cover property (SWITCH_DISCHARGE != 3'h0);
  cover property (REG_WR & ~WRITE_UNLOCKED & ~MONITOR_BLANK);
endmodule
bind swbuck_config_regs swbuck_monitor chk (.*);

// ===== testbench/tb_top.sv
// self-checking bench for the switch and buck register slice
// assumes the host model drives the register port at falling edges
`timescale 1ns/1ps
module tb_top
  import swbuck_pkg::*;
;
  logic [7:0] addr, wdata, rdata, w;
  logic       clk, rst, en, wr, rd, unl, apply, pf_n, s1, s2, blank, rd_q;
  logic [2:0] sw_en, sw_on, sw_dis;
  logic [5:0] t1, t2;
  logic [7:0] exp_q[$];
  int         num_errors, n_compared;
  swbuck_host_model host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .unlocked(unl), .apply(apply));
  swbuck_config_regs DUT (.CLK_SYS(clk), .SYS_RST(rst), .CLK_EN(en),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
    .REG_RDATA(rdata), .WRITE_UNLOCKED(unl), .VOLTAGE_APPLY(apply),
    .SWITCH_ENABLE(sw_en), .POWERFAIL_FLAG_LOW_N_PIN(pf_n),
    .SWITCH_ON(sw_on), .SWITCH_DISCHARGE(sw_dis), .BUCK_ONE_TARGET(t1),
    .BUCK_TWO_TARGET(t2), .BUCK_ONE_SKIP(s1), .BUCK_TWO_SKIP(s2),
    .MONITOR_BLANK(blank));
  // compare and count
  task automatic chk(input string n, input logic [7:0] e, g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  // note the expected byte, then read it
  task automatic rd_exp(input logic [7:0] a, e);
    exp_q.push_back(e);
    host.read(a);
  endtask
  task automatic report_and_stop();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // read data lands on the edge that samples the read strobe; checked at the next falling edge
  always @(posedge clk) rd_q <= rd & en & ~rst;
  always @(negedge clk) if (rd_q) chk("rdata", exp_q.pop_front(), rdata);
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #800000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    {rst, en, pf_n, sw_en} = 6'h38;
    void'($urandom(70));
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rd_exp(8'h15, 8'h00);
    rd_exp(8'h16, 8'h99);
    chk("target two", 8'h19, {2'h0, t2});
    host.write(8'h15, 8'hFF, 1'b1);
    host.write(8'h16, 8'hFF, 1'b1);
    rd_exp(8'h15, 8'h3F);
    rd_exp(8'h16, 8'hBF);
    chk("blank", 8'h01, {7'h0, blank});
    chk("target held", 8'h19, {2'h0, t1});
    host.write(8'h16, 8'h00, 1'b0);
    rd_exp(8'h16, 8'hBF);
    en = 1'b0;
    host.write(8'h17, 8'h00, 1'b1);
    en = 1'b1;
    rd_exp(8'h17, 8'h99);
    rd_exp(8'h18, 8'h00);
    // random codes and skip bits; codes taken on apply, skip bits at once
    repeat (8) begin
      w = 8'($urandom());
      host.write(8'h16, w, 1'b1);
      host.write(8'h17, ~w, 1'b1);
      rd_exp(8'h17, ~w & 8'hBF);
      host.go();
      chk("target one", {2'h0, w[5:0]}, {2'h0, t1});
      chk("target two", {2'h0, ~w[5:0]}, {2'h0, t2});
      chk("skip", {6'h0, w[7], ~w[7]}, {6'h0, s1, s2});
    end
    repeat (1000) @(negedge clk);
    chk("blank held", 8'h01, {7'h0, blank});
    // power fail cuts switches one and three, which then discharge
    sw_en = 3'h7;
    host.write(8'h15, 8'h2D, 1'b1);
    pf_n = 1'b0;
    repeat (6) @(negedge clk);
    chk("switch on", 8'h02, {5'h0, sw_on});
    chk("discharge", 8'h05, {5'h0, sw_dis});
    pf_n = 1'b1;
    repeat (6) @(negedge clk);
    chk("switch on", 8'h07, {5'h0, sw_on});
    chk("discharge", 8'h00, {5'h0, sw_dis});
    // mid-run reset restores defaults; a locked write must not blank
    rst = 1'b1;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk("rdata reset", 8'h00, rdata);
    chk("blank reset", 8'h00, {7'h0, blank});
    chk("target one", 8'h19, {2'h0, t1});
    host.write(8'h17, 8'h00, 1'b0);
    chk("blank locked", 8'h00, {7'h0, blank});
    rd_exp(8'h15, 8'h00);
    rd_exp(8'h17, 8'h99);
    report_and_stop();
  end
endmodule
